// [design/asrc_ctrl.sv]
// module: host controller driving the asynchronous 1k x 8 static memory pins
`timescale 1ns/1ns
module asrc_ctrl #(
   parameter int POWERUP_CYC = asrc_pkg::POWERUP_CYC
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // user request
   input wire logic i_req,
   input wire logic i_req_write,
   input wire logic [asrc_pkg::IDX_W-1:0] i_req_index,
   input wire logic [asrc_pkg::DATA_W-1:0] i_req_wdata,
   output logic o_req_ready,
   output logic o_done,
   output logic [asrc_pkg::DATA_W-1:0] o_rdata,
   // memory pins
   output logic [asrc_pkg::IDX_W-1:0] o_byte_index,
   output logic o_select_n,
   output logic o_drive_n,
   output logic o_wstrobe_n,
   input wire logic [asrc_pkg::DATA_W-1:0] i_data_io,
   output logic [asrc_pkg::DATA_W-1:0] o_data_io,
   output logic o_data_io_oe_n
);
   localparam logic [asrc_pkg::CNT_W-1:0] READ_CNT = asrc_pkg::CNT_W'(asrc_pkg::READ_CYC + 2);
   localparam logic [asrc_pkg::CNT_W-1:0] WPUL_CNT = asrc_pkg::CNT_W'(asrc_pkg::WPULSE_CYC);
   localparam logic [asrc_pkg::CNT_W-1:0] WHLD_CNT = asrc_pkg::CNT_W'(asrc_pkg::WHOLD_CYC);
   localparam logic [asrc_pkg::CNT_W-1:0] FLT_CNT = asrc_pkg::CNT_W'(asrc_pkg::FLOAT_CYC);
   localparam logic [asrc_pkg::CNT_W-1:0] GAP_CNT = asrc_pkg::CNT_W'(asrc_pkg::FLOAT_CYC);
   localparam logic [asrc_pkg::CNT_W-1:0] PWR_CNT = asrc_pkg::CNT_W'(POWERUP_CYC);

   asrc_pkg::asrc_state_t state_r, state_nxt;
   logic [asrc_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic [asrc_pkg::IDX_W-1:0] idx_r, idx_nxt;
   logic [asrc_pkg::DATA_W-1:0] wdata_r, wdata_nxt;
   logic [asrc_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
   logic sel_n_r, sel_n_nxt;
   logic drv_n_r, drv_n_nxt;
   logic wst_n_r, wst_n_nxt;
   logic oe_n_r, oe_n_nxt;
   logic done_r, done_nxt;
   logic [asrc_pkg::DATA_W-1:0] data_sync;

   // bus pins come from another timing world
   asrc_sync #(.W(asrc_pkg::DATA_W)) u_sync (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_async(i_data_io),
      .o_sync(data_sync)
   );

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      idx_nxt = idx_r;
      wdata_nxt = wdata_r;
      rdata_nxt = rdata_r;
      sel_n_nxt = sel_n_r;
      drv_n_nxt = drv_n_r;
      wst_n_nxt = wst_n_r;
      oe_n_nxt = oe_n_r;
      done_nxt = 1'b0;
      if (cnt_r != '0) begin
         cnt_nxt = cnt_r - 1'b1;
      end
      unique case (state_r)
         asrc_pkg::ASRC_PWR: begin
            if (cnt_r == '0) begin
               state_nxt = asrc_pkg::ASRC_IDLE;
            end
         end
         asrc_pkg::ASRC_IDLE: begin
            if (i_req) begin
               idx_nxt = i_req_index;
               wdata_nxt = i_req_wdata;
               sel_n_nxt = 1'b0;
               if (i_req_write) begin
                  drv_n_nxt = 1'b1;
                  cnt_nxt = FLT_CNT;
                  state_nxt = asrc_pkg::ASRC_WFLT;
               end else begin
                  drv_n_nxt = 1'b0;
                  cnt_nxt = READ_CNT;
                  state_nxt = asrc_pkg::ASRC_READ;
               end
            end
         end
         asrc_pkg::ASRC_READ: begin
            if (cnt_r == '0) begin
               rdata_nxt = data_sync;
               done_nxt = 1'b1;
               sel_n_nxt = 1'b1;
               drv_n_nxt = 1'b1;
               cnt_nxt = GAP_CNT;
               state_nxt = asrc_pkg::ASRC_GAP;
            end
         end
         // let the memory float before we drive
         asrc_pkg::ASRC_WFLT: begin
            if (cnt_r == '0) begin
               // data driven a whole pulse before rise
               oe_n_nxt = 1'b0;
               // strobe falls last, index already stable
               wst_n_nxt = 1'b0;
               cnt_nxt = WPUL_CNT;
               state_nxt = asrc_pkg::ASRC_WPUL;
            end
         end
         // width and lead time kept, index held
         asrc_pkg::ASRC_WPUL: begin
            if (cnt_r == '0) begin
               wst_n_nxt = 1'b1;
               cnt_nxt = WHLD_CNT;
               state_nxt = asrc_pkg::ASRC_WHLD;
            end
         end
         asrc_pkg::ASRC_WHLD: begin
            if (cnt_r == '0) begin
               oe_n_nxt = 1'b1;
               sel_n_nxt = 1'b1;
               done_nxt = 1'b1;
               cnt_nxt = GAP_CNT;
               state_nxt = asrc_pkg::ASRC_GAP;
            end
         end
         // spacing and bus float before next access
         asrc_pkg::ASRC_GAP: begin
            if (cnt_r == '0) begin
               state_nxt = asrc_pkg::ASRC_IDLE;
            end
         end
         default: begin
            state_nxt = asrc_pkg::ASRC_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= asrc_pkg::ASRC_PWR;
         cnt_r <= PWR_CNT;
         idx_r <= '0;
         wdata_r <= '0;
         rdata_r <= '0;
         sel_n_r <= 1'b1;
         drv_n_r <= 1'b1;
         wst_n_r <= 1'b1;
         oe_n_r <= 1'b1;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         idx_r <= idx_nxt;
         wdata_r <= wdata_nxt;
         rdata_r <= rdata_nxt;
         sel_n_r <= sel_n_nxt;
         drv_n_r <= drv_n_nxt;
         wst_n_r <= wst_n_nxt;
         oe_n_r <= oe_n_nxt;
         done_r <= done_nxt;
      end
   end

   assign o_req_ready = (state_r == asrc_pkg::ASRC_IDLE);
   assign o_done = done_r;
   assign o_rdata = rdata_r;
   assign o_byte_index = idx_r;
   assign o_select_n = sel_n_r;
   assign o_drive_n = drv_n_r;
   assign o_wstrobe_n = wst_n_r;
   assign o_data_io = wdata_r;
   assign o_data_io_oe_n = oe_n_r;

   // write data driven and stable when strobe rises
   AST_WDATA_SETUP: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(wst_n_r) |-> !oe_n_r && $stable(wdata_r)) else $error("write data not set up");
   // drive never low while strobe low
   AST_DRIVE_HIGH: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      !wst_n_r |-> drv_n_r) else $error("drive low during write");
   AST_INDEX_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      !wst_n_r |-> $stable(idx_r)) else $error("index moved in write");
   sequence s_pulse;
      $fell(wst_n_r) ##0 !wst_n_r [*8];
   endsequence
   AST_PULSE_WIDTH: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      $fell(wst_n_r) |-> s_pulse) else $error("write pulse too short");
   AST_WDATA_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(wst_n_r) |-> !oe_n_r [*2]) else $error("write data hold short");
   // write finished by strobe while select low
   AST_STROBE_END: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(sel_n_r) |-> wst_n_r) else $error("select rose before strobe");
   AST_WRITE_SEL: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      !wst_n_r |-> !sel_n_r) else $error("strobe low without select");
   // no access before power up wait
   AST_POWERUP: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      state_r == asrc_pkg::ASRC_PWR |-> sel_n_r) else $error("access during power up");
   // read data sampled a full access after select
   AST_READ_TIME: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      $fell(sel_n_r) && !drv_n_r |-> !sel_n_r [*8] ##1 !sel_n_r [*6])
      else $error("read ended early");
   // we never drive while memory may drive
   AST_NO_CLASH: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      !oe_n_r |-> drv_n_r) else $error("bus contention");
endmodule : asrc_ctrl

// [design/asrc_pkg.sv]
// package: timing constants and types for the async sram host controller
package asrc_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int IDX_W = 10;
   localparam int DATA_W = 8;
   localparam int DEPTH = 1024;
   // slowest grade figures, in ns, so any grade part is met
   localparam int INDEX_ACCESS_TIME_NS = 120;
   localparam int SELECT_ACCESS_TIME_NS = 60;
   localparam int DRIVE_FLOAT_TIME_NS = 30;
   localparam int WRITE_FLOAT_TIME_NS = 30;
   localparam int INDEX_SETUP_TIME_NS = 0;
   localparam int INDEX_HOLD_TIME_NS = 40;
   localparam int STROBE_WIDTH_NS = 45;
   localparam int STROBE_LEAD_TIME_NS = 75;
   localparam int WDATA_SETUP_TIME_NS = 10;
   localparam int WDATA_HOLD_TIME_NS = 15;
   localparam int READ_PERIOD_NS = 120;
   localparam int WRITE_PERIOD_NS = 120;
   localparam int POWERUP_WAIT_NS = 2000000;
   // least times round up to whole cycles
   localparam int READ_CYC = (INDEX_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam int WPULSE_CYC = (STROBE_LEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WHOLD_CYC = (WDATA_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FLOAT_CYC = (DRIVE_FLOAT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WPERIOD_CYC = (WRITE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POWERUP_CYC = (POWERUP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 18;
   typedef enum logic [2:0] {
      ASRC_PWR = 3'b000,
      ASRC_IDLE = 3'b001,
      ASRC_READ = 3'b011,
      ASRC_WFLT = 3'b010,
      ASRC_WPUL = 3'b110,
      ASRC_WHLD = 3'b111,
      ASRC_GAP = 3'b101
   } asrc_state_t;
endpackage : asrc_pkg

// [design/asrc_sync.sv]
// module: two flop synchroniser for the data bus pins
`timescale 1ns/1ns
module asrc_sync #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // data
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= i_async;
         sync_r <= meta_r;
      end
   end
   assign o_sync = sync_r;
endmodule : asrc_sync

// [dv/asrc_mem_model.sv]
// model: behavioural 1k x 8 static memory on the controller's far side
`timescale 1ns/1ns
module asrc_mem_model #(
   parameter int ACC_NS = 120,
   parameter int SEL_NS = 60
) (
   // memory pins
   input wire logic [9:0] i_byte_index,
   input wire logic i_select_n,
   input wire logic i_drive_n,
   input wire logic i_wstrobe_n,
   input wire logic [7:0] i_data_io,
   // bus drive
   output logic [7:0] o_data_io,
   output logic o_data_io_oe_n
);
   logic [7:0] mem [1024];
   logic [9:0] cap_idx;
   logic en;
   time valid_at = 0;
   always @(i_byte_index) valid_at = $time + ACC_NS;
   always @(negedge i_select_n or negedge i_drive_n)
      if ($time + SEL_NS > valid_at) valid_at = $time + SEL_NS;
   assign en = !i_select_n && !i_drive_n && i_wstrobe_n;
   assign #(30, 0) o_data_io_oe_n = !en;
   // invalid data is shown inverted, never the stored byte early
   always #1 o_data_io = ($time >= valid_at) ? mem[i_byte_index] : ~mem[i_byte_index];
   // index latched at later falling edge
   always @(negedge i_select_n or negedge i_wstrobe_n)
      if (!i_select_n && !i_wstrobe_n) cap_idx = i_byte_index;
   always @(posedge i_wstrobe_n)
      if (i_select_n === 1'b0) mem[cap_idx] = i_data_io;
endmodule : asrc_mem_model

// [dv/tb_top.sv]
// testbench: directed tests of the sram host controller with a memory model
`timescale 1ns/1ns
module tb_top;
   localparam int PWR = 4;
   logic i_clk_sys = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_req = 1'b0;
   logic i_req_write = 1'b0;
   logic [9:0] i_req_index = 10'h000;
   logic [7:0] i_req_wdata = 8'h00;
   logic o_req_ready, o_done, o_select_n, o_drive_n, o_wstrobe_n, o_data_io_oe_n, mem_oe_n;
   logic [7:0] o_rdata, o_data_io, mem_data, data_bus, rd, prev_dat;
   logic [7:0] last_bus = 8'h00;
   logic [9:0] o_byte_index, prev_idx;
   logic [1:0] w_hist = 2'b11;
   int wlow = 0;
   int fail_count = 0;
   int num_checks = 0;
   asrc_ctrl #(.POWERUP_CYC(PWR)) asrc_ctrl_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
      .i_req(i_req), .i_req_write(i_req_write), .i_req_index(i_req_index),
      .i_req_wdata(i_req_wdata), .o_req_ready(o_req_ready), .o_done(o_done), .o_rdata(o_rdata),
      .o_byte_index(o_byte_index), .o_select_n(o_select_n), .o_drive_n(o_drive_n),
      .o_wstrobe_n(o_wstrobe_n), .i_data_io(data_bus), .o_data_io(o_data_io),
      .o_data_io_oe_n(o_data_io_oe_n));
   asrc_mem_model asrc_mem_model_inst (.i_byte_index(o_byte_index), .i_select_n(o_select_n),
      .i_drive_n(o_drive_n), .i_wstrobe_n(o_wstrobe_n), .i_data_io(data_bus),
      .o_data_io(mem_data), .o_data_io_oe_n(mem_oe_n));
   // an undriven bus toggles every cycle
   assign data_bus = (o_data_io_oe_n === 1'b0) ? o_data_io :
      ((mem_oe_n === 1'b0) ? mem_data : ~last_bus);
   initial forever #5 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys) last_bus <= data_bus;
   task automatic check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("MISMATCH at %0t ns: %s", $time, msg);
      end
   endtask : check
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_of_test
   // pin monitor at falling edge, away from register updates
   always @(negedge i_clk_sys) begin
      if (i_rst_n) begin
         check(!(o_data_io_oe_n === 1'b0 && mem_oe_n === 1'b0), "bus contention");
         if (o_wstrobe_n === 1'b0) begin
            wlow++;
            check(o_drive_n === 1'b1 && o_select_n === 1'b0, "strobe without select");
            check(o_byte_index === prev_idx, "index moved in write");
         end else if (wlow > 0) begin
            check(wlow == asrc_pkg::WPULSE_CYC + 1, "strobe width");
            wlow = 0;
         end
         if (w_hist != 2'b11)
            check(o_data_io_oe_n === 1'b0 && o_data_io === prev_dat, "write data moved");
         if (w_hist[0] == 1'b0 && o_wstrobe_n === 1'b1)
            check(o_select_n === 1'b0, "write not ended by strobe");
      end
      w_hist <= {w_hist[0], o_wstrobe_n};
      prev_idx <= o_byte_index;
      prev_dat <= o_data_io;
   end
   // selector instead of a ref argument, which free tools handle poorly
   task automatic wait_hi(input bit want_done, output int n);
      n = 0;
      while ((want_done ? o_done : o_req_ready) !== 1'b1) begin
         @(posedge i_clk_sys);
         #1;
         n++;
         if (n > 400) begin
            check(1'b0, "timeout");
            end_of_test();
         end
      end
   endtask : wait_hi
   task automatic xfer(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
         output logic [7:0] q);
      int n;
      int exp_n;
      wait_hi(1'b0, n);
      i_req = 1'b1;
      i_req_write = wr;
      i_req_index = idx;
      i_req_wdata = wd;
      @(posedge i_clk_sys);
      #1;
      i_req = 1'b0;
      wait_hi(1'b1, n);
      // each counted phase lasts one cycle past its count
      exp_n = wr ? asrc_pkg::FLOAT_CYC + asrc_pkg::WPULSE_CYC + asrc_pkg::WHOLD_CYC + 3 :
         asrc_pkg::READ_CYC + 3;
      check(n == exp_n, "transfer length");
      q = o_rdata;
   endtask : xfer
   task automatic t_power;
      int n;
      wait_hi(1'b0, n);
      check(n >= PWR && n <= PWR + 2, "power up wait");
      $display("test power done");
   endtask : t_power
   task automatic t_rw(input logic [9:0] ia [4], input logic [7:0] da [4]);
      foreach (ia[i]) xfer(1'b1, ia[i], da[i], rd);
      foreach (ia[i]) begin
         xfer(1'b0, ia[i], 8'h00, rd);
         check(rd === da[i], "read back");
      end
      $display("test read write done");
   endtask : t_rw
   task automatic t_reset_mid;
      fork
         xfer(1'b1, 10'h3ff, 8'h11, rd);
         begin
            repeat (8) @(posedge i_clk_sys);
            #1;
            i_rst_n = 1'b0;
         end
      join_any
      disable fork;
      i_req = 1'b0;
      #2;
      check(o_select_n === 1'b1 && o_wstrobe_n === 1'b1, "pins in reset");
      check(o_data_io_oe_n === 1'b1 && o_done === 1'b0, "bus in reset");
      repeat (2) @(posedge i_clk_sys);
      #1;
      i_rst_n = 1'b1;
      t_power();
      xfer(1'b0, 10'h000, 8'h00, rd);
      check(rd === 8'h0f, "data kept over reset");
      $display("test reset done");
   endtask : t_reset_mid
   initial begin
      repeat (6) @(posedge i_clk_sys);
      #1;
      i_rst_n = 1'b1;
      t_power();
      t_rw('{10'h000, 10'h3ff, 10'h155, 10'h2aa}, '{8'h5a, 8'ha5, 8'h3c, 8'hc3});
      t_rw('{10'h155, 10'h156, 10'h000, 10'h2ab}, '{8'hf0, 8'h01, 8'h0f, 8'hff});
      t_reset_mid();
      end_of_test();
   end
endmodule : tb_top
